/* logic/sca_conv.sv */
// Conversion start, busy timing and 3-state readout of the sampling converter.
`timescale 1ns/100ps
`include "sca_cfg.svh"
module sca_conv (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Control pins from the host, asynchronous
  input  wire sca_pkg::sca_ctl_t  ctl_in,
  // Sample word from the hold stage, same clock
  input  wire sca_pkg::sca_word_t sample_in,
  // Parallel data bus and busy flag
  output sca_pkg::sca_bus_t       bus_out,
  output logic                    busy_n
);
  import sca_pkg::*;

  localparam int UPD_CYC  = `SCA_UPD_CYC;
  localparam int PREV_CYC = `SCA_PREV_CYC;
  localparam int BUSY_CYC = `SCA_BUSY_CYC;
  localparam int ACC_CYC  = `SCA_ACC_CYC;
  localparam int D3_CYC   = `SCA_D3_CYC;
  localparam int CORE_CYC = `SCA_CORE_CYC;
  // Pin to busy fall takes three cycles: two sync stages and the state flop.
  localparam int ACC_WIN_CYC = ACC_CYC - 3;

  // Two-stage synchroniser on the host pins.
  sca_ctl_t ctl_meta_reg;
  sca_ctl_t ctl_sync_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_meta_reg <= '{cs_n: 1'b1, rd_conv: 1'b1, byte_sel: 1'b0};
      ctl_sync_reg <= '{cs_n: 1'b1, rd_conv: 1'b1, byte_sel: 1'b0};
    end else begin
      ctl_meta_reg <= ctl_in;
      ctl_sync_reg <= ctl_meta_reg;
    end
  end

  // Select and read/convert are ORed low-active and level triggered.
  logic conv_req;
  logic bus_en;
  assign conv_req = !ctl_sync_reg.cs_n && !ctl_sync_reg.rd_conv; // RULE_04
  assign bus_en   = !ctl_sync_reg.cs_n && ctl_sync_reg.rd_conv; // RULE_13

  // Conversion sequencer state.
  sca_state_t state_reg, state_next;
  logic [`SCA_CNT_W-1:0] cnt_reg, cnt_next;
  sca_word_t hold_reg, hold_next;
  sca_word_t out_reg, out_next;
  logic      pend_reg, pend_next;
  logic      busy_n_reg, busy_n_next;

  // Two-entry result buffer between the core and the output latch.
  sca_word_t buf_mem [`SCA_BUF_DEPTH];
  logic      buf_wp_reg, buf_wp_next;
  logic      buf_rp_reg, buf_rp_next;
  logic [1:0] buf_cnt_reg, buf_cnt_next;
  logic      buf_in_valid, buf_in_ready;
  logic      buf_out_valid, buf_out_ready;
  sca_word_t buf_out_data;

  assign buf_in_ready  = (buf_cnt_reg != 2'h2);
  assign buf_out_valid = (buf_cnt_reg != 2'h0);
  assign buf_out_data  = buf_mem[buf_rp_reg];

  always_comb begin
    buf_wp_next  = buf_wp_reg;
    buf_rp_next  = buf_rp_reg;
    buf_cnt_next = buf_cnt_reg;
    if (buf_in_valid && buf_in_ready) begin
      buf_wp_next = !buf_wp_reg;
    end
    if (buf_out_valid && buf_out_ready) begin
      buf_rp_next = !buf_rp_reg;
    end
    case ({buf_in_valid && buf_in_ready, buf_out_valid && buf_out_ready})
      2'b10:   buf_cnt_next = buf_cnt_reg + 2'h1;
      2'b01:   buf_cnt_next = buf_cnt_reg - 2'h1;
      default: buf_cnt_next = buf_cnt_reg;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_wp_reg  <= 1'b0;
      buf_rp_reg  <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      buf_wp_reg  <= buf_wp_next;
      buf_rp_reg  <= buf_rp_next;
      buf_cnt_reg <= buf_cnt_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SCA_BUF_DEPTH; gi++) begin : g_buf
      always_ff @(posedge clk) begin
        if (buf_in_valid && buf_in_ready && (buf_wp_reg == 1'(gi))) begin
          buf_mem[gi] <= hold_reg;
        end
      end
    end
  endgenerate

  // Conversion sequencer.
  // The core pushes once its result is ready; a full buffer stalls it.
  assign buf_in_valid  = pend_reg && (state_reg == SCA_CONV) &&
                         (cnt_reg >= `SCA_CNT_W'(CORE_CYC));
  // The old word is replaced only at the update slot, so reads during the
  // early part of a conversion still see the previous result.
  assign buf_out_ready = (state_reg == SCA_CONV) &&
                         (cnt_reg >= `SCA_CNT_W'(UPD_CYC)); // RULE_01

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    hold_next   = hold_reg;
    out_next    = out_reg;
    pend_next   = pend_reg;
    busy_n_next = busy_n_reg;
    if (buf_in_valid && buf_in_ready) begin
      pend_next = 1'b0;
    end
    unique case (state_reg)
      SCA_IDLE: begin
        // Commands only count here, never while busy is low.
        if (conv_req) begin // RULE_12
          state_next  = SCA_CONV;
          cnt_next    = '0;
          hold_next   = sample_in;
          pend_next   = 1'b1;
          busy_n_next = 1'b0;
        end
      end
      SCA_CONV: begin
        cnt_next = cnt_reg + `SCA_CNT_W'(1);
        if (buf_out_valid && buf_out_ready) begin // RULE_08
          out_next   = buf_out_data; // RULE_06
          state_next = SCA_SETTLE;
          cnt_next   = '0;
        end
      end
      SCA_SETTLE: begin
        cnt_next = cnt_reg + `SCA_CNT_W'(1);
        if (cnt_reg == `SCA_CNT_W'(D3_CYC - 1)) begin // RULE_09
          busy_n_next = 1'b1; // RULE_07
          state_next  = SCA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg  <= SCA_IDLE;
      cnt_reg    <= '0;
      hold_reg   <= '0;
      out_reg    <= '0;
      pend_reg   <= 1'b0;
      busy_n_reg <= 1'b1;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      hold_reg   <= hold_next;
      out_reg    <= out_next;
      pend_reg   <= pend_next;
      busy_n_reg <= busy_n_next;
    end
  end

  // Output pins; the byte view puts the low byte on the upper eight pins.
  sca_bus_t bus_reg, bus_next;
  always_comb begin
    bus_next.oe = bus_en; // RULE_13
    if (ctl_sync_reg.byte_sel) begin
      bus_next.data = {out_reg[7:0], out_reg[11:8]}; // RULE_14
    end else begin
      bus_next.data = out_reg; // RULE_14
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_reg <= '{data: '0, oe: 1'b0};
    end else begin
      bus_reg <= bus_next;
    end
  end

  assign bus_out = bus_reg;
  assign busy_n  = busy_n_reg;

  // Checks on the converter side of the handshake.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [`SCA_CNT_W-1:0] low_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst || busy_n_reg) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != '1) begin
      low_cnt_reg <= low_cnt_reg + `SCA_CNT_W'(1);
    end
  end

  a_busy_max_width: assert property ( // RULE_07
    low_cnt_reg < `SCA_CNT_W'(BUSY_CYC))
    else $error("busy held low too long");

  a_data_access_max: assert property ( // RULE_06
    $fell(busy_n_reg) |->
      ##[1:ACC_WIN_CYC] (busy_n_reg && out_reg == hold_reg))
    else $error("new data not in time");

  a_prev_data_hold: assert property ( // RULE_08
    $fell(busy_n_reg) |-> $stable(out_reg)[*8])
    else $error("previous data dropped early");

  a_prev_data_window: assert property ( // RULE_01
    (!busy_n_reg && low_cnt_reg < `SCA_CNT_W'(PREV_CYC)) |=> $stable(out_reg))
    else $error("previous data changed inside its window");

  a_busy_after_data: assert property ( // RULE_09
    $changed(out_reg) |-> !busy_n_reg ##1 !busy_n_reg)
    else $error("busy rose too soon after data");

  a_ignore_while_busy: assert property ( // RULE_12
    (!busy_n_reg && state_reg == SCA_CONV) |=> $stable(hold_reg))
    else $error("command accepted while busy");

  a_start_on_request: assert property ( // RULE_04
    (state_reg == SCA_IDLE && conv_req) |=> !busy_n_reg)
    else $error("request did not start a conversion");

  a_bus_enable_rule: assert property ( // RULE_13
    bus_reg.oe == $past(bus_en))
    else $error("bus enable wrong");

  a_byte_view: assert property ( // RULE_14
    $past(ctl_sync_reg.byte_sel) |-> bus_reg.data[11:4] == $past(out_reg[7:0]))
    else $error("byte view wrong");

  c_full_conversion: cover property (
    $fell(busy_n_reg) ##[1:120] $rose(busy_n_reg));
  c_read_during_conv: cover property (!busy_n_reg && bus_reg.oe);
  c_byte_read: cover property (
    bus_reg.oe && $changed(bus_reg.data) && !$changed(out_reg));
endmodule

/* include/sca_cfg.svh */
// Constants for the converter start and readout handshake.
// Contract
// RULE_01 - After a start, the old result stays on the bus until update.
// RULE_02 - Host must not read from old-data expiry until busy rises.
// RULE_03 - Host should avoid reading the bus at all during a conversion; the bench reads the old word for 55 cycles early in each one.
// RULE_04 - With select low, read/convert low starts, high enables outputs.
// RULE_05 - Host holds the convert command low between 40 ns and 1750 ns.
// RULE_06 - New data is valid on the bus at most 3.2 us after start.
// RULE_07 - Busy stays low at most 2.2 us per conversion.
// RULE_08 - Previous data stays valid at least 1.5 us after start.
// RULE_09 - Busy rises at least 35 ns after the new data is valid; here busy_n rises one 20 ns cycle after bus_out data changes.
// RULE_10 - Host spaces conversion starts at least 4 us apart.
// RULE_11 - Host sets read/convert 10 ns before chip select initiates.
// RULE_12 - Every conversion command is ignored while busy is low.
// RULE_13 - The bus is driven only with read/convert high and select low.
// RULE_14 - Results are 12-bit two's complement, full word or two bytes.
// RULE_15 - A clocked host rounds minimum intervals up, latches on busy rise.
`ifndef SCA_CFG_SVH
`define SCA_CFG_SVH

`define SCA_CLK_NS        20
`define SCA_T_PREV_MIN_NS 1500
`define SCA_T_UPD_NS      2000
`define SCA_T_BUSY_MAX_NS 2200
`define SCA_T_ACC_MAX_NS  3200
`define SCA_T_D3_MIN_NS   35
`define SCA_T_CORE_NS     1000

`define SCA_UPD_CYC  (`SCA_T_UPD_NS / `SCA_CLK_NS)
`define SCA_PREV_CYC ((`SCA_T_PREV_MIN_NS + `SCA_CLK_NS - 1) / `SCA_CLK_NS)
`define SCA_BUSY_CYC (`SCA_T_BUSY_MAX_NS / `SCA_CLK_NS)
`define SCA_ACC_CYC  (`SCA_T_ACC_MAX_NS / `SCA_CLK_NS)
`define SCA_D3_CYC   ((`SCA_T_D3_MIN_NS + `SCA_CLK_NS - 1) / `SCA_CLK_NS)
`define SCA_CORE_CYC (`SCA_T_CORE_NS / `SCA_CLK_NS)

`define SCA_WORD_W 12
`define SCA_BYTE_W 8
`define SCA_CNT_W  8
`define SCA_BUF_DEPTH 2

`endif

/* include/sca_pkg.sv */
// Types shared by the converter handshake block.
package sca_pkg;
  typedef logic [11:0] sca_word_t;
  typedef struct packed {
    logic cs_n;
    logic rd_conv;
    logic byte_sel;
  } sca_ctl_t;
  typedef struct packed {
    sca_word_t data;
    logic      oe;
  } sca_bus_t;
  typedef enum logic [1:0] {
    SCA_IDLE,
    SCA_CONV,
    SCA_SETTLE
  } sca_state_t;
endpackage

/* tb/sca_host.sv */
// Host controller model driving the converter's control pins.
`timescale 1ns/100ps
module sca_host (
  // Clock
  input  wire logic         clk,
  // Control pins
  output sca_pkg::sca_ctl_t ctl
);
  import sca_pkg::*;
  realtime t_last;
  initial begin
    ctl = '{cs_n: 1'b1, rd_conv: 1'b1, byte_sel: 1'b0};
    t_last = -1.0e6;
  end
  task automatic pins(input logic cs, input logic rc, input int n);
    @(posedge clk);
    ctl.cs_n <= cs;
    ctl.rd_conv <= rc;
    repeat (n - 1) @(posedge clk);
  endtask
  task automatic view(input logic b);
    @(posedge clk);
    ctl.byte_sel <= b;
  endtask
  // Starts wait a full 4 us so the hold stage can reacquire.
  task automatic start;
    while ($realtime - t_last < 4000.0) @(posedge clk);
    pins(1'b1, 1'b0, 1);
    t_last = $realtime;
    pins(1'b0, 1'b0, 2);
    pins(1'b0, 1'b1, 1);
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the converter handshake.
`timescale 1ns/100ps
module tb;
  import sca_pkg::*;
  logic      clk;
  logic      rst;
  sca_ctl_t  ctl;
  sca_word_t sample;
  sca_bus_t  bus;
  logic      busy_n;
  sca_word_t prev;
  int        failures;
  int        cmp_count;
  wire [11:0] dbus = bus.oe ? bus.data : 12'hzzz;
  sca_conv i_dut (.clk(clk), .rst(rst), .ctl_in(ctl), .sample_in(sample),
                  .bus_out(bus), .busy_n(busy_n));
  sca_host i_host (.clk(clk), .ctl(ctl));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask
  task automatic wrap_up;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_conv(input sca_word_t w, input bit poke);
    int      n;
    realtime t_fall;
    n = 0;
    @(posedge clk);
    sample <= w;
    i_host.start();
    while (busy_n !== 1'b0 && n < 10) begin
      tick();
      n++;
    end
    check(busy_n === 1'b0, "busy did not fall");
    t_fall = $realtime;
    repeat (5) tick();
    n = 5;
    // Early read of the old word; later reads are avoided for noise.
    repeat (55) begin
      tick();
      n++;
      check(dbus === prev, "old result lost");
    end
    if (poke) i_host.pins(1'b0, 1'b0, 2);
    i_host.pins(1'b1, 1'b1, 1);
    while (busy_n !== 1'b1 && n < 150) begin
      tick();
      n++;
    end
    check($realtime - t_fall <= 2200.0, "busy low too long");
    i_host.pins(1'b0, 1'b1, 5);
    #1 check(dbus === w, "new result missing");
    i_host.view(1'b1);
    repeat (5) tick();
    check(dbus === {w[7:0], w[11:8]}, "byte view wrong");
    i_host.view(1'b0);
    repeat (20) begin
      tick();
      check(busy_n === 1'b1, "stray conversion");
    end
    check(dbus === w, "word view wrong");
    prev = w;
  endtask
  task automatic t_idle;
    i_host.pins(1'b1, 1'b1, 5);
    #1 check(bus.oe === 1'b0, "bus driven");
    i_host.pins(1'b1, 1'b0, 5);
    #1 check(bus.oe === 1'b0 && busy_n === 1'b1, "idle pins acted");
    i_host.pins(1'b1, 1'b1, 1);
  endtask
  initial begin
    rst = 1'b1;
    sample = 12'h000;
    prev = 12'h000;
    failures = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tick();
    check(busy_n === 1'b1 && bus.oe === 1'b0, "reset state");
    t_conv(12'h7ff, 1'b0);
    t_conv(12'h800, 1'b1);
    t_conv(12'hfff, 1'b0);
    t_idle();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
